/* verification/adc_seq_chk.sv */
`timescale 1ns/1ns
module adc_seq_chk
  import adc_seq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        dma_request,
  input wire logic        sample_hold,
  input wire logic [4:0]  sample_chan,
  input wire logic        resolution_select
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_seq_end;
    $fell(sample_hold);
  endsequence

  property p_wr_resp;
    s_wr_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not on time");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response not on time");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read response repeated");
  property p_ready_open;
    s_axi_bvalid |-> s_axi_awready && s_axi_wready;
  endproperty
  a_ready_open: assert property (p_ready_open)
    else $error("write channel not reopened with response");
  property p_unmapped_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("refused read returned data");
  property p_req_pulse;
    dma_request |=> !dma_request;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("transfer request longer than one cycle");
  property p_req_after_seq;
    s_seq_end |-> ##[0:3] dma_request;
  endproperty
  a_req_after_seq: assert property (p_req_after_seq)
    else $error("no transfer request after sequence");
  property p_single_chan;
    resolution_select && sample_hold && $past(sample_hold)
      |-> $stable(sample_chan);
  endproperty
  a_single_chan: assert property (p_single_chan)
    else $error("channel moved in single channel mode");
endmodule

bind adc_seq_top adc_seq_chk #(.ADDR_W(ADDR_W)) adc_seq_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .dma_request(dma_request),
  .sample_hold(sample_hold), .sample_chan(sample_chan),
  .resolution_select(resolution_select));

/* verification/adc_sequencer_dma_addressing_test.sv */
`timescale 1ns/1ns
module adc_sequencer_dma_addressing_test;
  import adc_seq_pkg::*;
  logic        aclk, aresetn, ext_trigger, dma_request, sample_hold;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, resolution_select;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, analog_pin_mask, seen, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, result_format, rsp;
  logic [2:0]  vref_select;
  logic [4:0]  sample_chan;
  logic [11:0] dma_addr, last_addr;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          req_count;

  adc_seq_top adc_seq_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger(ext_trigger), .dma_request(dma_request),
    .dma_addr(dma_addr), .sample_chan(sample_chan),
    .sample_hold(sample_hold), .vref_select(vref_select),
    .result_format(result_format), .resolution_select(resolution_select),
    .analog_pin_mask(analog_pin_mask));
  dma_ctrl_model dma_ctrl_model_inst (
    .aclk(aclk), .aresetn(aresetn), .dma_request(dma_request),
    .dma_addr(dma_addr), .req_count(req_count), .last_addr(last_addr));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk)
    if (sample_hold)
      seen[sample_chan] <= 1'b1;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input string nm,
                        input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    chk(nm, e, rd);
  endtask

  task automatic run_seq(input logic ext, input logic [31:0] c1,
                         input int n);
    int r0;
    r0 = req_count;
    seen = '0;
    if (ext)
    begin
      @(posedge aclk);
      ext_trigger <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_trigger <= 1'b0;
    end
    else
      wr(OFF_CTRL_ONE, c1 | (32'h1 << SAMP_BIT));
    while (req_count == r0)
      @(posedge aclk);
    repeat (40) @(posedge aclk);
    chk("requests", r0 + 1, req_count);
    chk("channels", ((32'h1 << n) - 1) << 5, seen);
  endtask

  task automatic test_regs;
    for (int i = 0; i < 7; i++)
      rd_chk(8'(4 * i), "reset value", 32'h0);
    wr(OFF_CTRL_FOUR, 32'hFFFF);
    rd_chk(OFF_CTRL_FOUR, "ctrl four", 32'h7);
    wr(8'h20, 32'h1);
    chk("unmapped write", RESP_SLVERR, rsp);
    rd_chk(8'h20, "unmapped read", 32'h0);
    chk("unmapped resp", RESP_SLVERR, rsp);
    wr(OFF_PIN_LOW, 32'hA5A5);
    wr(OFF_PIN_HIGH, 32'h5A5A);
    chk("pin mask", 32'h5A5AA5A5, analog_pin_mask);
    wr(OFF_CTRL_TWO, 32'hA300);
    chk("vref", 32'h5, vref_select);
    rd_chk(OFF_CTRL_TWO, "ctrl two", 32'hA300);
    wr(OFF_CTRL_THR, 32'h0101);
    rd_chk(OFF_CTRL_THR, "ctrl three", 32'h0101);
  endtask

  task automatic test_manual;
    wr(OFF_SCAN, 32'h5);
    wr(OFF_CTRL_ONE, 32'h0400);
    chk("resolution", 32'h1, resolution_select);
    wr(OFF_CTRL_ONE, 32'h8400);
    for (int l = 0; l < 8; l++)
    begin
      wr(OFF_CTRL_FOUR, 32'(l));
      run_seq(1'b0, 32'h8400, 1);
      chk("dma index", 32'h5, 32'(last_addr >> l));
    end
    rd_chk(OFF_STATUS, "flag set", 32'h1);
    wr(OFF_STATUS, 32'h0);
    rd_chk(OFF_STATUS, "flag clear", 32'h0);
    wr(OFF_CTRL_ONE, 32'h8000);
    chk("resolution locked", 32'h1, resolution_select);
    wr(OFF_CTRL_ONE, 32'h0);
    wr(OFF_CTRL_ONE, 32'h0);
    chk("resolution cleared", 32'h0, resolution_select);
  endtask

  task automatic test_external;
    wr(OFF_CTRL_ONE, 32'h1220);
    wr(OFF_CTRL_ONE, 32'h9220);
    chk("format", 32'h2, result_format);
    rd_chk(OFF_CTRL_ONE, "ctrl one", 32'h9220);
    run_seq(1'b1, 32'h0, 4);
    chk("dma order", 32'h3, 32'(last_addr));
  endtask

  task automatic test_auto;
    int r0;
    r0 = req_count;
    wr(OFF_CTRL_ONE, 32'h80E0);
    while (req_count < r0 + 2)
      @(posedge aclk);
    wr(OFF_CTRL_ONE, 32'h0);
    repeat (200) @(posedge aclk);
    r0 = req_count;
    repeat (200) @(posedge aclk);
    chk("auto stops", r0, req_count);
  endtask

  initial
  begin
    aresetn = 1'b0;
    ext_trigger = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs;
    test_manual;
    test_external;
    test_auto;
    complete_run;
  end
endmodule

/* verification/dma_ctrl_model.sv */
`timescale 1ns/1ns
module dma_ctrl_model
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        dma_request,
  input  wire logic [11:0] dma_addr,
  output int               req_count,
  output logic [11:0]      last_addr
);
  initial req_count = 0;
  // one transfer per request pulse
  always @(posedge aclk)
    if (aresetn && dma_request)
    begin
      req_count <= req_count + 1;
      last_addr <= dma_addr;
    end
endmodule

/* verilog/adc_conv_seq.sv */
`timescale 1ns/1ns
module adc_conv_seq
  import adc_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        res12,
  input  wire logic [1:0]  chps,
  input  wire logic [7:0]  adcs,
  input  wire logic [4:0]  samc,
  input  wire logic [4:0]  base_chan,
  adc_seq_if.seq           sq
);
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} seq_state_t;
  seq_state_t  state_q, state_d;
  logic [7:0]  div_q, div_d;
  logic [5:0]  tad_q, tad_d;
  logic [1:0]  slot_q, slot_d;
  logic        done_q, done_d;
  logic        tick;
  logic [1:0]  nslots;
  assign tick = (div_q == adcs);
  // one channel in 12-bit; up to four in 10-bit
  assign nslots = res12 ? 2'h0 : (chps[1] ? 2'h3 : {1'b0, chps[0]});
  always_comb
  begin
    state_d = state_q;
    div_d   = tick ? 8'h00 : div_q + 8'h01;
    tad_d   = tad_q;
    slot_d  = slot_q;
    done_d  = 1'b0;
    unique case (state_q)
      S_IDLE:
      begin
        div_d = 8'h00;
        if (sq.start)
        begin
          state_d = S_SAMPLE;
          tad_d   = 6'h00;
          slot_d  = 2'h0;
        end
      end
      S_SAMPLE:
        if (tick)
        begin
          if (tad_q >= {1'b0, samc})
          begin
            state_d = S_CONVERT;
            tad_d   = 6'h00;
          end
          else
            tad_d = tad_q + 6'h01;
        end
      S_CONVERT:
        if (tick)
        begin
          if (tad_q == 6'(CONV_TAD - 1))
          begin
            tad_d = 6'h00;
            if (slot_q == nslots)
            begin
              state_d = S_IDLE;
              done_d  = 1'b1;
            end
            else
              slot_d = slot_q + 2'h1;
          end
          else
            tad_d = tad_q + 6'h01;
        end
    endcase
  end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      state_q <= S_IDLE;
      div_q   <= 8'h00;
      tad_q   <= 6'h00;
      slot_q  <= 2'h0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      div_q   <= div_d;
      tad_q   <= tad_d;
      slot_q  <= slot_d;
      done_q  <= done_d;
    end
  assign sq.busy = (state_q != S_IDLE);
  assign sq.done = done_q;
  assign sq.slot = slot_q;
  assign sq.chan = base_chan + {3'h0, slot_q};
  assign sq.last = (slot_q == nslots);
endmodule

/* verilog/adc_dma_addr.sv */
`timescale 1ns/1ns
module adc_dma_addr
  import adc_seq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clear,
  input  wire logic              conv_done,
  input  wire logic              seq_done,
  input  wire logic [4:0]        chan,
  input  wire logic              order_mode,
  input  wire logic [2:0]        len_code,
  input  wire logic [3:0]        incr_rate,
  output logic [ADDR_W-1:0]      addr
);
  if (ADDR_W < 12)
  begin : g_bad_width
    $error("ADDR_W too small for 32 inputs of 128 words");
  end
  logic [ADDR_W-1:0] seq_q, seq_d;
  logic [6:0]        ptr_q, ptr_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [6:0]        mask;
  assign mask = 7'((8'h01 << len_code) - 8'h01);
  always_comb
  begin
    seq_d = seq_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    if (clear)
    begin
      seq_d = '0;
      ptr_d = 7'h00;
      cnt_d = 4'h0;
    end
    else
    begin
      if (conv_done)
        seq_d = seq_q + ADDR_W'(1);
      if (seq_done)
      begin
        if (cnt_q == incr_rate)
        begin
          cnt_d = 4'h0;
          ptr_d = (ptr_q + 7'h01) & mask;
        end
        else
          cnt_d = cnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      seq_q <= '0;
      ptr_q <= 7'h00;
      cnt_q <= 4'h0;
    end
    else
    begin
      seq_q <= seq_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
    end
  assign addr = order_mode ? seq_q
              : ADDR_W'(({7'h00, chan} << len_code) | {5'h00, ptr_q & mask});
endmodule

/* verilog/adc_seq_if.sv */
`timescale 1ns/1ns
interface adc_seq_if;
  logic       start;
  logic       busy;
  logic       done;
  logic [4:0] chan;
  logic [1:0] slot;
  logic       last;
  modport ctrl (output start, input busy, input done, input chan,
                input slot, input last);
  modport seq  (input start, output busy, output done, output chan,
                output slot, output last);
endinterface

/* verilog/adc_seq_pkg.sv */
// Notes on behaviour
// - 12-bit mode uses one sample/hold channel only.
// - 10-bit mode samples up to four inputs at once.
// - input selection addresses channels 0 to 31.
// - reference source is a three-bit field, control two 15:13.
// - conversion clock divider is control three bits 7:0.
// - sample/hold channel count is control two bits 9:8.
// - trigger is control one 7:5, sample time control three 12:8.
// - result format is control one bits 9:8.
// - one DMA request each time the flag sets per sequence.
// - control two bits 5:2 set sequences per pointer advance, less one.
// - buffer mode one gives addresses in conversion order.
// - buffer mode zero gives scatter/gather addresses.
// - buffer length code n gives two to the n words.
// - control four bits 15:3 read zero; length resets zero.
// - control one bit 10 selects 12-bit; reset is 10-bit.
package adc_seq_pkg;
  localparam logic [7:0] OFF_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO  = 8'h04;
  localparam logic [7:0] OFF_CTRL_THR  = 8'h08;
  localparam logic [7:0] OFF_CTRL_FOUR = 8'h0C;
  localparam logic [7:0] OFF_PIN_LOW   = 8'h10;
  localparam logic [7:0] OFF_PIN_HIGH  = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_SCAN      = 8'h1C;
  localparam int EN_BIT     = 15;
  localparam int BUFMODE_BIT = 12;
  localparam int RES_BIT    = 10;
  localparam int FMT_LSB    = 8;
  localparam int TRIG_LSB   = 5;
  localparam int SAMP_BIT   = 1;
  localparam int VREF_LSB   = 13;
  localparam int CHPS_LSB   = 8;
  localparam int INCR_LSB   = 2;
  localparam int SAMC_LSB   = 8;
  localparam int ADCS_LSB   = 0;
  localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
  localparam logic [15:0] CTRL_THR_RST = 16'h0000;
  localparam logic [2:0]  LEN_RST      = 3'h0;
  localparam logic [2:0]  TRIG_MANUAL  = 3'h0;
  localparam logic [2:0]  TRIG_AUTO    = 3'h7;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int CONV_TAD   = 12;
  localparam int TAD_W      = 8;
endpackage

/* verilog/adc_seq_top.sv */
`timescale 1ns/1ns
module adc_seq_top
  import adc_seq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_trigger,
  output logic                   dma_request,
  output logic [ADDR_W-1:0]      dma_addr,
  output logic [4:0]             sample_chan,
  output logic                   sample_hold,
  output logic [2:0]             vref_select,
  output logic [1:0]             result_format,
  output logic                   resolution_select,
  output logic [31:0]            analog_pin_mask
);
  logic [15:0] ctrl1_q, ctrl1_d;
  logic [15:0] ctrl2_q, ctrl2_d;
  logic [15:0] ctrl3_q, ctrl3_d;
  logic [2:0]  len_q, len_d;
  logic [15:0] pinl_q, pinl_d;
  logic [15:0] pinh_q, pinh_d;
  logic [4:0]  scan_q, scan_d;
  logic        flag_q, flag_d;
  logic        aw_q, aw_d, w_q, w_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic        bv_q, bv_d;
  logic [1:0]  br_q, br_d;
  logic        rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  rr_q, rr_d;
  logic        req_q, req_d;
  logic [ADDR_W-1:0] addr_q;
  logic [4:0]  chan_q;
  logic        hold_q;
  logic [2:0]  trg_s;
  logic        trg_prev_q;
  logic        start;
  logic        wr_fire;
  logic [31:0] rword;
  logic        rhit;
  logic [ADDR_W-1:0] addr_w;
  adc_seq_if   sq();

  adc_conv_seq u_seq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .res12     (ctrl1_q[RES_BIT]),
    .chps      (ctrl2_q[CHPS_LSB+1:CHPS_LSB]),
    .adcs      (ctrl3_q[ADCS_LSB+7:ADCS_LSB]),
    .samc      (ctrl3_q[SAMC_LSB+4:SAMC_LSB]),
    .base_chan (scan_q),
    .sq        (sq.seq)
  );

  adc_dma_addr #(.ADDR_W(ADDR_W)) u_addr (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (!ctrl1_q[EN_BIT]),
    // one step per stored result: slot advance or sequence end
    .conv_done  (sq.done || (sq.busy && hold_q && sq.chan != chan_q)),
    .seq_done   (sq.done),
    .chan       (sq.chan),
    .order_mode (ctrl1_q[BUFMODE_BIT]),
    .len_code   (len_q),
    .incr_rate  (ctrl2_q[INCR_LSB+3:INCR_LSB]),
    .addr       (addr_w)
  );

  // external trigger synchroniser, second and third stages compared
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      trg_s      <= 3'h0;
      trg_prev_q <= 1'b0;
    end
    else
    begin
      trg_s <= {trg_s[1:0], ext_trigger};
      if (trg_s[1] == trg_s[2])
        trg_prev_q <= trg_s[2];
    end

  always_comb
  begin
    start = 1'b0;
    if (ctrl1_q[EN_BIT] && !sq.busy)
      unique case (ctrl1_q[TRIG_LSB+2:TRIG_LSB])
        TRIG_MANUAL: start = ctrl1_q[SAMP_BIT];
        TRIG_AUTO:   start = 1'b1;
        default:     start = (trg_s[1] == trg_s[2]) && trg_s[2]
                             && !trg_prev_q;
      endcase
  end
  assign sq.start = start;

  assign wr_fire = aw_q && w_q && !bv_q;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb
  begin
    rhit = 1'b1;
    unique case (s_axi_araddr)
      OFF_CTRL_ONE:  rword = {16'h0000, ctrl1_q};
      OFF_CTRL_TWO:  rword = {16'h0000, ctrl2_q};
      OFF_CTRL_THR:  rword = {16'h0000, ctrl3_q};
      OFF_CTRL_FOUR: rword = {29'h0, len_q};
      OFF_PIN_LOW:   rword = {16'h0000, pinl_q};
      OFF_PIN_HIGH:  rword = {16'h0000, pinh_q};
      OFF_STATUS:    rword = {30'h0, sq.busy, flag_q};
      OFF_SCAN:      rword = {27'h0, scan_q};
      default:
      begin
        rword = 32'h0000_0000;
        rhit  = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    ctrl3_d = ctrl3_q;
    len_d   = len_q;
    pinl_d  = pinl_q;
    pinh_d  = pinh_q;
    scan_d  = scan_q;
    flag_d  = flag_q;
    aw_d    = aw_q || s_axi_awvalid;
    awa_d   = (s_axi_awvalid && !aw_q) ? s_axi_awaddr : awa_q;
    w_d     = w_q || s_axi_wvalid;
    wd_d    = (s_axi_wvalid && !w_q) ? s_axi_wdata : wd_q;
    ws_d    = (s_axi_wvalid && !w_q) ? s_axi_wstrb : ws_q;
    bv_d    = bv_q && !s_axi_bready;
    br_d    = br_q;
    rv_d    = rv_q && !s_axi_rready;
    rd_d    = rd_q;
    rr_d    = rr_q;
    req_d   = 1'b0;
    if (start && ctrl1_q[TRIG_LSB+2:TRIG_LSB] == TRIG_MANUAL)
      ctrl1_d[SAMP_BIT] = 1'b0;
    if (wr_fire)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      unique case (awa_q)
        OFF_CTRL_ONE:
        begin
          ctrl1_d = merge(ctrl1_q, wd_q, ws_q);
          if (ctrl1_q[EN_BIT])
            ctrl1_d[RES_BIT] = ctrl1_q[RES_BIT];
        end
        OFF_CTRL_TWO:  ctrl2_d = merge(ctrl2_q, wd_q, ws_q);
        OFF_CTRL_THR:  ctrl3_d = merge(ctrl3_q, wd_q, ws_q);
        OFF_CTRL_FOUR: if (ws_q[0]) len_d = wd_q[2:0];
        OFF_PIN_LOW:   pinl_d = merge(pinl_q, wd_q, ws_q);
        OFF_PIN_HIGH:  pinh_d = merge(pinh_q, wd_q, ws_q);
        OFF_STATUS:    if (ws_q[0] && !wd_q[0]) flag_d = 1'b0;
        OFF_SCAN:      if (ws_q[0]) scan_d = wd_q[4:0];
        default:       br_d = RESP_SLVERR;
      endcase
    end
    // flag set wins over clear, one request per sequence
    if (sq.done)
    begin
      flag_d = 1'b1;
      req_d  = 1'b1;
    end
    if (s_axi_arvalid && !rv_q)
    begin
      rv_d = 1'b1;
      rd_d = rword;
      rr_d = rhit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ctrl1_q <= CTRL_ONE_RST;
      ctrl2_q <= CTRL_TWO_RST;
      ctrl3_q <= CTRL_THR_RST;
      len_q   <= LEN_RST;
      pinl_q  <= 16'h0000;
      pinh_q  <= 16'h0000;
      scan_q  <= 5'h00;
      flag_q  <= 1'b0;
      aw_q    <= 1'b0;
      awa_q   <= 8'h00;
      w_q     <= 1'b0;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
      bv_q    <= 1'b0;
      br_q    <= RESP_OKAY;
      rv_q    <= 1'b0;
      rd_q    <= 32'h0000_0000;
      rr_q    <= RESP_OKAY;
      req_q   <= 1'b0;
      addr_q  <= '0;
      chan_q  <= 5'h00;
      hold_q  <= 1'b0;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ctrl3_q <= ctrl3_d;
      len_q   <= len_d;
      pinl_q  <= pinl_d;
      pinh_q  <= pinh_d;
      scan_q  <= scan_d;
      flag_q  <= flag_d;
      aw_q    <= aw_d;
      awa_q   <= awa_d;
      w_q     <= w_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
      req_q   <= req_d;
      addr_q  <= addr_w;
      chan_q  <= sq.chan;
      hold_q  <= sq.busy;
    end

  assign s_axi_awready     = !aw_q;
  assign s_axi_wready      = !w_q;
  assign s_axi_bvalid      = bv_q;
  assign s_axi_bresp       = br_q;
  assign s_axi_arready     = !rv_q;
  assign s_axi_rvalid      = rv_q;
  assign s_axi_rdata       = rd_q;
  assign s_axi_rresp       = rr_q;
  assign dma_request       = req_q;
  assign dma_addr          = addr_q;
  assign sample_chan       = chan_q;
  assign sample_hold       = hold_q;
  assign vref_select       = ctrl2_q[VREF_LSB+2:VREF_LSB];
  assign result_format     = ctrl1_q[FMT_LSB+1:FMT_LSB];
  assign resolution_select = ctrl1_q[RES_BIT];
  assign analog_pin_mask   = {pinh_q, pinl_q};
endmodule
